/* rtl/adc_control_result_regs.sv */
// adc_control_result_regs: control and result registers of one 12-bit
// converter, with conversion clock divider and analog routing selects.
// assumes the analog core reports done with a one-cycle pulse on aclk
// and a slow subsidiary clock that arrives asynchronously on a pin.
//
// Overview of operation
// - justify clear: result left-aligned, msb at high bit 7, low bits 3..0 zero
// - justify set: result right-aligned, msb at high bit 3, high 7..4 zero
// - result bits not carrying data always read zero
// - software pulses start high then low to request one conversion
// - start rising resets converter and sets pending flag; waits for fall
// - pending flag read-only, one while converting, zero after; resets to one
// - power-down bit zero powers converter on; resets to one
// - channel codes 0 to 7 route external analog inputs 0 to 7
// - code 8 routes demodulation amp, 9 to 15 overcurrent amp
// - top channel bit set routes bandgap regardless of lower bits
// - bandgap enable bit turns reference on; resets to zero
// - bandgap off when unused by converter and low-voltage functions off
// - reference code 00 supply, 01 external pin, 1x internal reference
// - clock codes 0..6 divide system clock by 1..64, code 7 slow clock
// - second control bit 7 reads zero; other fields reset zero
// - port select bit set makes pin analog and removes digital function
// - analog-selected pins lose their pull-high resistor
// - conversion end clears pending flag and raises interrupt request
// - reference code 01 gives the shared pin to the converter
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module adc_control_result_regs
    import adc_ctrl_pkg::*;
(
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // axi4-lite slave
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog core
    input wire logic conv_done,
    input wire logic [11:0] conv_result,
    input wire logic sub_clk_pin,
    output logic conv_clk,
    output logic conv_reset,
    output logic conv_run,
    output logic conv_power_on,
    output logic [3:0] source_sel,
    output logic [2:0] ext_channel,
    output logic [1:0] ref_sel,
    output logic bandgap_on,
    output logic ref_pin_analog,
    output logic conv_irq_req,
    // port a pin control
    output logic [15:0] pin_analog,
    output logic [15:0] pin_pullup_block
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic start_q, pend_q, pwrdn_q;
    logic [4:0] chan_q;
    logic [6:0] second_q;
    logic [15:0] port_sel_q;
    logic lvrd_q;
    logic [11:0] result_q;
    logic [3:0] st_q;
    logic aw_q, w_q;
    logic [4:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    function automatic logic [15:0] justify(input logic [11:0] r,
                                            input logic right);
        justify = right ? {4'h0, r} : {r, 4'h0};
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
        merge = s[0] ? d[7:0] : old;
    endfunction

    // ------------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------------
    // address and data may arrive in either order; each is latched once
    logic wr_fire, bad_wr;
    assign s_axi_awready = clk_en && !aw_q && !s_axi_bvalid;
    assign s_axi_wready = clk_en && !w_q && !s_axi_bvalid;
    assign wr_fire = clk_en && aw_q && w_q && !s_axi_bvalid;
    assign bad_wr = awaddr_q > ADDR_SYS_CFG || awaddr_q[1:0] != 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 5'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= bad_wr ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wr_first, wr_second;
    logic [7:0] ctrl_first_wr, ctrl_second_wr;
    assign wr_first = wr_fire && awaddr_q == ADDR_CTRL_FIRST;
    assign wr_second = wr_fire && awaddr_q == ADDR_CTRL_SECOND;
    assign ctrl_first_wr = merge({start_q, pend_q, pwrdn_q, chan_q}, wdata_q,
                                 wstrb_q);
    assign ctrl_second_wr = merge({1'b0, second_q}, wdata_q, wstrb_q);

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_q <= CTRL_FIRST_RST[CF_START_BIT];
            pwrdn_q <= CTRL_FIRST_RST[CF_PWRDN_BIT];
            chan_q <= CTRL_FIRST_RST[4:0];
            second_q <= CTRL_SECOND_RST[6:0];
            port_sel_q <= {PORT_SEL_RST, PORT_SEL_RST};
            lvrd_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_first) begin
                start_q <= ctrl_first_wr[CF_START_BIT];
                pwrdn_q <= ctrl_first_wr[CF_PWRDN_BIT];
                chan_q <= ctrl_first_wr[4:0];
            end
            if (wr_second) begin
                second_q <= ctrl_second_wr[6:0];
            end
            if (wr_fire && awaddr_q == ADDR_PORT_SEL_LOW) begin
                port_sel_q[7:0] <= merge(port_sel_q[7:0], wdata_q, wstrb_q);
            end
            if (wr_fire && awaddr_q == ADDR_PORT_SEL_HIGH) begin
                port_sel_q[15:8] <= merge(port_sel_q[15:8], wdata_q,
                                          wstrb_q);
            end
            if (wr_fire && awaddr_q == ADDR_SYS_CFG && wstrb_q[0]) begin
                lvrd_q <= wdata_q[SC_LVRD_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------------
    // the start bit is edge-detected from its own registered value, so a
    // single write toggling it is seen exactly once
    logic start_d1_q;
    conv_state_t st;
    assign st = conv_state_t'(st_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_d1_q <= 1'b0;
            st_q <= ST_IDLE;
            pend_q <= CTRL_FIRST_RST[CF_PEND_BIT];
            conv_irq_req <= 1'b0;
        end else if (clk_en) begin
            start_d1_q <= start_q;
            conv_irq_req <= 1'b0;
            // rising start resets and flags pending
            if (start_q && !start_d1_q) begin
                st_q <= ST_RESET;
                pend_q <= 1'b1;
            end else begin
                case (st)
                    ST_RESET: if (!start_q) begin
                        st_q <= ST_CONVERT;
                    end
                    ST_CONVERT: if (conv_done) begin
                        st_q <= ST_IDLE;
                        pend_q <= 1'b0;
                        conv_irq_req <= 1'b1;
                    end
                    ST_IDLE, ST_OFF: st_q <= st_q;
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    // result captured whole at conversion end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_q <= 12'h000;
        end else if (clk_en && st == ST_CONVERT && conv_done) begin
            result_q <= conv_result;
        end
    end

    assign conv_reset = st == ST_RESET;
    assign conv_run = st == ST_CONVERT;
    assign conv_power_on = !pwrdn_q;

    // ------------------------------------------------------------------
    // conversion clock divider
    // ------------------------------------------------------------------
    // slow clock is sampled, so it is only usable when well below aclk
    logic sub_s1_q, sub_s2_q;
    logic [5:0] div_q;
    logic [6:0] div_all;
    logic [2:0] ck_sel;
    assign ck_sel = second_q[CS_CLK_LSB +: 3];
    assign div_all = {div_q, aclk};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            div_q <= 6'h00;
        end else if (clk_en) begin
            sub_s1_q <= sub_clk_pin;
            sub_s2_q <= sub_s1_q;
            div_q <= div_q + 6'h01;
        end
    end

    // divide by 1..64 or slow clock
    always_comb begin
        if (ck_sel == CLK_SUB) begin
            conv_clk = sub_s2_q;
        end else if (ck_sel == 3'h0) begin
            conv_clk = aclk;
        end else begin
            conv_clk = div_all[ck_sel];
        end
    end

    // ------------------------------------------------------------------
    // analog routing
    // ------------------------------------------------------------------
    always_comb begin
        ext_channel = chan_q[2:0];
        if (chan_q[4]) begin
            source_sel = SRC_BANDGAP;
        end else if (!chan_q[3]) begin
            source_sel = SRC_EXT;
        end else if (chan_q == CH_DEMOD) begin
            source_sel = SRC_DEMOD;
        end else begin
            source_sel = SRC_OVERCUR;
        end
    end

    assign ref_sel = second_q[CS_REF_LSB +: 2];
    assign ref_pin_analog = ref_sel == REF_EXT_PIN;
    assign bandgap_on = (second_q[CS_BGEN_BIT] && !pwrdn_q) || lvrd_q;
    assign pin_analog = port_sel_q;
    assign pin_pullup_block = port_sel_q;

    // ------------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------------
    logic [15:0] res_j;
    logic [7:0] rd_byte;
    logic rd_bad;
    assign res_j = justify(result_q, second_q[CS_JUST_BIT]);
    assign s_axi_arready = clk_en && !s_axi_rvalid;

    always_comb begin
        rd_bad = 1'b0;
        case (s_axi_araddr)
            ADDR_RESULT_HIGH: rd_byte = res_j[15:8];
            ADDR_RESULT_LOW: rd_byte = res_j[7:0];
            ADDR_CTRL_FIRST: rd_byte = {start_q, pend_q, pwrdn_q, chan_q};
            ADDR_CTRL_SECOND: rd_byte = {1'b0, second_q} & SECOND_MASK;
            ADDR_PORT_SEL_LOW: rd_byte = port_sel_q[7:0];
            ADDR_PORT_SEL_HIGH: rd_byte = port_sel_q[15:8];
            ADDR_SYS_CFG: rd_byte = {7'h00, lvrd_q};
            default: begin
                rd_byte = 8'h00;
                rd_bad = 1'b1;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= rd_bad ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    left_justify_a: assert property (!second_q[CS_JUST_BIT] |->
        res_j[15:4] == result_q && res_j[3:0] == 4'h0)
        else $error("left layout wrong");
    right_justify_a: assert property (second_q[CS_JUST_BIT] |->
        res_j == {4'h0, result_q})
        else $error("right layout wrong");
    start_pending_a: assert property (clk_en && start_q
        && !start_d1_q |=> pend_q && st == ST_RESET)
        else $error("start rise did not set pending");
    hold_reset_a: assert property (st == ST_RESET && start_q
        && clk_en |=> st == ST_RESET)
        else $error("conversion began while start high");
    end_clear_a: assert property (clk_en && st == ST_CONVERT
        && conv_done && !(start_q && !start_d1_q)
        |=> !pend_q && conv_irq_req && result_q == $past(conv_result))
        else $error("conversion end not handled");
    result_hold_a: assert property (!(clk_en && conv_done)
        |=> $stable(result_q))
        else $error("result changed without end");
    bandgap_route_a: assert property (chan_q[4] |->
        source_sel == SRC_BANDGAP)
        else $error("bandgap not routed");
    ref_pin_a: assert property (clk_en && wr_second && wstrb_q[0]
        |=> ref_pin_analog == (wdata_q[CS_REF_LSB +: 2] == REF_EXT_PIN))
        else $error("reference pin mismatch");

    conv_done_c: cover property (st == ST_CONVERT && conv_done && clk_en);
    restart_c: cover property (st == ST_CONVERT && start_q && !start_d1_q);
    right_read_c: cover property (s_axi_rvalid && second_q[CS_JUST_BIT]);

endmodule
`default_nettype wire

/* rtl/adc_ctrl_pkg.sv */
// adc_ctrl_pkg: register map, field positions, reset values and encodings
// for the converter control and result register block.
// assumes a 32-bit axi4-lite register bus, one register per aligned word.
package adc_ctrl_pkg;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_RESULT_HIGH = 5'h00;
    localparam logic [4:0] ADDR_RESULT_LOW = 5'h04;
    localparam logic [4:0] ADDR_CTRL_FIRST = 5'h08;
    localparam logic [4:0] ADDR_CTRL_SECOND = 5'h0C;
    localparam logic [4:0] ADDR_PORT_SEL_LOW = 5'h10;
    localparam logic [4:0] ADDR_PORT_SEL_HIGH = 5'h14;
    localparam logic [4:0] ADDR_SYS_CFG = 5'h18;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CF_START_BIT = 7;
    localparam int CF_PEND_BIT = 6;
    localparam int CF_PWRDN_BIT = 5;
    localparam int CS_BGEN_BIT = 6;
    localparam int CS_JUST_BIT = 5;
    localparam int CS_REF_LSB = 3;
    localparam int CS_CLK_LSB = 0;
    localparam int SC_LVRD_BIT = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_FIRST_RST = 8'h60;
    localparam logic [7:0] CTRL_SECOND_RST = 8'h00;
    localparam logic [7:0] PORT_SEL_RST = 8'h00;
    localparam logic [7:0] SECOND_MASK = 8'h7F;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    localparam logic [4:0] CH_DEMOD = 5'h08;
    localparam logic [1:0] REF_SUPPLY = 2'h0;
    localparam logic [1:0] REF_EXT_PIN = 2'h1;
    localparam logic [2:0] CLK_SUB = 3'h7;

    typedef enum logic [3:0] {
        SRC_EXT = 4'h1,
        SRC_DEMOD = 4'h2,
        SRC_OVERCUR = 4'h4,
        SRC_BANDGAP = 4'h8
    } source_t;

    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_RESET = 4'h2,
        ST_CONVERT = 4'h4,
        ST_IDLE = 4'h8
    } conv_state_t;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* verification/adc_control_result_regs_tb.sv */
// adc_control_result_regs_tb: register and conversion tests over axi4-lite.
// assumes the core model answers a conversion in a fixed number of cycles.
`timescale 1ns/100ps
`default_nettype none
module adc_control_result_regs_tb;
    import adc_ctrl_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic sub_clk = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, conv_done, conv_clk;
    logic conv_reset, conv_run, conv_power_on, ref_pin_analog;
    logic conv_irq_req, bandgap_on;
    logic [1:0] bresp, rresp, ref_sel, resp;
    logic [31:0] rdata, rd;
    logic [11:0] conv_result;
    logic [11:0] sample = 12'h000;
    logic [3:0] source_sel;
    logic [2:0] ext_channel;
    logic [15:0] pin_analog, pin_pullup_block;
    logic [3:0] bg_tab [4] = '{4'b0101, 4'b1100, 4'b0011, 4'b0000};
    // bandgap settle wait in cycles, a plain margin
    localparam int BG_SETTLE = 50;
    int n_mismatch = 0;
    int compares = 0;
    int edges = 0;
    int e0;

    always #20 aclk = ~aclk;
    // slow clock pin, unrelated in phase to aclk
    always #370 sub_clk = ~sub_clk;
    always @(posedge conv_clk) edges++;

    adc_control_result_regs i_dut (
        .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .conv_done(conv_done), .conv_result(conv_result),
        .sub_clk_pin(sub_clk), .conv_clk(conv_clk),
        .conv_reset(conv_reset), .conv_run(conv_run),
        .conv_power_on(conv_power_on), .source_sel(source_sel),
        .ext_channel(ext_channel), .ref_sel(ref_sel),
        .bandgap_on(bandgap_on), .ref_pin_analog(ref_pin_analog),
        .conv_irq_req(conv_irq_req), .pin_analog(pin_analog),
        .pin_pullup_block(pin_pullup_block)
    );

    adc_core_model i_core (
        .aclk(aclk), .aresetn(aresetn), .conv_run(conv_run),
        .conv_power_on(conv_power_on), .sample(sample),
        .conv_done(conv_done), .conv_result(conv_result)
    );

    // ------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------
    task automatic check_val(input string name, input logic [31:0] exp,
                             input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // edge counts across an async mux may be off by one
    task automatic check_near(input string name, input int exp,
                              input int got);
        compares++;
        if (got < exp - 1 || got > exp + 1) begin
            n_mismatch++;
            $display("ERROR %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic axi_write(input logic [4:0] a, input logic [7:0] d);
        logic aw_go, w_go, b_go;
        int n;
        b_go = 1'b0;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_go && n < 100) begin
            @(negedge aclk);
            aw_go = awvalid && (awready === 1'b1);
            w_go = wvalid && (wready === 1'b1);
            b_go = (bvalid === 1'b1);
            resp = bresp;
            @(posedge aclk);
            if (aw_go) awvalid <= 1'b0;
            if (w_go) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        if (!b_go) n_mismatch++;
        @(negedge aclk);
    endtask

    task automatic axi_read(input logic [4:0] a);
        logic ar_go, r_go;
        int n;
        r_go = 1'b0;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_go && n < 100) begin
            @(negedge aclk);
            ar_go = arvalid && (arready === 1'b1);
            r_go = (rvalid === 1'b1);
            rd = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ar_go) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        if (!r_go) n_mismatch++;
    endtask

    task automatic read_check(input logic [4:0] a, input logic [7:0] exp,
                              input string name);
        axi_read(a);
        check_val(name, {24'h000000, exp}, rd);
    endtask

    task automatic run_conv(input logic [11:0] v);
        int n;
        @(posedge aclk);
        sample <= v;
        axi_write(ADDR_CTRL_FIRST, 8'h80);
        check_val("conv_reset", 32'h1, {31'h0, conv_reset});
        check_val("conv_run", 32'h0, {31'h0, conv_run});
        read_check(ADDR_CTRL_FIRST, 8'hC0, "ctrl_first");
        axi_write(ADDR_CTRL_FIRST, 8'h00);
        check_val("conv_run", 32'h1, {31'h0, conv_run});
        read_check(ADDR_CTRL_FIRST, 8'h40, "ctrl_first");
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (conv_irq_req !== 1'b1 && n < 200);
        check_val("irq", 32'h1, {31'h0, conv_irq_req});
        @(negedge aclk);
        check_val("irq", 32'h0, {31'h0, conv_irq_req});
        check_val("conv_run", 32'h0, {31'h0, conv_run});
        read_check(ADDR_CTRL_FIRST, 8'h00, "ctrl_first");
        @(posedge aclk);
        sample <= ~v;
        for (int j = 0; j < 2; j++) begin
            axi_write(ADDR_CTRL_SECOND, {2'b00, j[0], 5'h00});
            read_check(ADDR_RESULT_HIGH, j ? {4'h0, v[11:8]} : v[11:4],
                       "result_high");
            read_check(ADDR_RESULT_LOW, j ? v[7:0] : {v[3:0], 4'h0},
                       "result_low");
        end
        $display("test conversion done");
    endtask

    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic logic [3:0] exp_src(input logic [4:0] c);
        if (c[4]) return 4'h8;
        if (c == 5'h08) return 4'h2;
        if (c[3]) return 4'h4;
        return 4'h1;
    endfunction

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        read_check(ADDR_CTRL_FIRST, 8'h60, "ctrl_first");
        read_check(ADDR_CTRL_SECOND, 8'h00, "ctrl_second");
        check_val("power_on", 32'h0, {31'h0, conv_power_on});
        axi_write(ADDR_CTRL_SECOND, 8'hFF);
        read_check(ADDR_CTRL_SECOND, 8'h7F, "ctrl_second");
        axi_write(5'h1C, 8'h01);
        check_val("bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        axi_read(5'h1C);
        check_val("rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        check_val("rdata", 32'h0, rd);
        $display("test registers done");
        for (int c = 0; c < 32; c++) begin
            axi_write(ADDR_CTRL_FIRST, {3'b000, c[4:0]});
            check_val("source", {28'h0, exp_src(c[4:0])},
                      {28'h0, source_sel});
            check_val("ext_ch", {29'h0, c[2:0]}, {29'h0, ext_channel});
        end
        check_val("power_on", 32'h1, {31'h0, conv_power_on});
        for (int r = 0; r < 4; r++) begin
            axi_write(ADDR_CTRL_SECOND, {3'b000, r[1:0], 3'b000});
            check_val("ref_sel", r, {30'h0, ref_sel});
            check_val("ref_pin", {31'h0, r == 1},
                      {31'h0, ref_pin_analog});
        end
        $display("test routing done");
        for (int k = 0; k < 8; k++) begin
            axi_write(ADDR_CTRL_SECOND, {5'h00, k[2:0]});
            repeat (4) @(negedge aclk);
            e0 = edges;
            repeat (128) @(negedge aclk);
            check_near("conv_clk", k == 7 ? 7 : 128 >> k, edges - e0);
        end
        $display("test clock done");
        for (int i = 0; i < 4; i++) begin
            axi_write(ADDR_SYS_CFG, {7'h00, bg_tab[i][1]});
            axi_write(ADDR_CTRL_FIRST, {2'b00, bg_tab[i][3], 5'h00});
            axi_write(ADDR_CTRL_SECOND, {1'b0, bg_tab[i][2], 6'h00});
            check_val("bandgap", {31'h0, bg_tab[i][0]},
                      {31'h0, bandgap_on});
        end
        axi_write(ADDR_PORT_SEL_LOW, 8'hA5);
        axi_write(ADDR_PORT_SEL_HIGH, 8'h3C);
        check_val("pin_analog", 32'h3CA5, {16'h0, pin_analog});
        check_val("pullup_off", 32'h3CA5, {16'h0, pin_pullup_block});
        read_check(ADDR_PORT_SEL_LOW, 8'hA5, "port_sel");
        $display("test pins done");
        axi_write(ADDR_CTRL_SECOND, 8'h40);
        check_val("bandgap", 32'h1, {31'h0, bandgap_on});
        repeat (BG_SETTLE) @(posedge aclk);
        run_conv(12'hABC);
        run_conv(12'h5F1);
        axi_write(ADDR_CTRL_FIRST, 8'h20);
        check_val("power_on", 32'h0, {31'h0, conv_power_on});
        finish_test;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        finish_test;
    end
endmodule
`default_nettype wire

/* verification/adc_core_model.sv */
// adc_core_model: behavioural analog converter core for the register block.
// assumes the block raises conv_run for one conversion and that the result
// is only looked at while conv_done is high.
`timescale 1ns/100ps
`default_nettype none
module adc_core_model #(
    parameter int LATENCY = 20
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control from the block
    input wire logic conv_run,
    input wire logic conv_power_on,
    input wire logic [11:0] sample,
    // answer to the block
    output logic conv_done,
    output logic [11:0] conv_result
);
    int cnt;

    // converts only while run, ends with one done pulse
    always_ff @(posedge aclk) begin
        if (!aresetn || !conv_run || !conv_power_on) begin
            cnt <= 0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= (cnt == LATENCY - 1);
            cnt <= (cnt == LATENCY) ? cnt : cnt + 1;
        end
    end

    // outside the done cycle the bus carries the inverse, not a stale value
    assign conv_result = conv_done ? sample : ~sample;
endmodule
`default_nettype wire
